//--- rtl/sfch_pkg.sv
package sfch_pkg;
    // Command opcode and subcommand codes in Features
    localparam logic [7:0] OPC_MONITOR = 8'hB0;
    localparam logic [7:0] SUB_DISABLE = 8'hD9;
    localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
    localparam logic [7:0] SUB_ENABLE = 8'hD8;
    localparam logic [7:0] SUB_RD_THRESH = 8'hD1;
    // Key that must sit in the cylinder registers
    localparam logic [7:0] KEY_CYL_LO = 8'h4F;
    localparam logic [7:0] KEY_CYL_HI = 8'hC2;
    // Autosave sector count codes
    localparam logic [7:0] AS_OFF = 8'h00;
    localparam logic [7:0] AS_ON = 8'hF1;
    // Threshold block geometry
    localparam int unsigned BLK_BYTES = 512;
    localparam logic [8:0] LAST_FETCH = 9'h1FE;
    localparam logic [7:0] LAST_WORD = 8'hFF;
    // Register byte offsets
    localparam logic [5:0] OFS_FEAT = 6'h00;
    localparam logic [5:0] OFS_SECCNT = 6'h04;
    localparam logic [5:0] OFS_CYL_LO = 6'h08;
    localparam logic [5:0] OFS_CYL_HI = 6'h0C;
    localparam logic [5:0] OFS_CMD = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;
    localparam logic [5:0] OFS_ERROR = 6'h18;
    localparam logic [5:0] OFS_DATA = 6'h1C;
    localparam logic [5:0] OFS_CTRL = 6'h20;
    localparam logic [5:0] OFS_STATE = 6'h24;
    // Status and error bit positions
    localparam int unsigned ST_BSY_BIT = 7;
    localparam int unsigned ST_DRDY_BIT = 6;
    localparam int unsigned ST_DRQ_BIT = 3;
    localparam int unsigned ST_ERR_BIT = 0;
    localparam int unsigned ER_ABRT_BIT = 2;
    // Control register bit positions
    localparam int unsigned CT_DRDY_BIT = 0;
    localparam int unsigned CT_ASSUP_BIT = 1;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [7:0] TF_RST = 8'h00;
    // Timing: clock rate and the command response limit
    localparam longint unsigned CLK_HZ = 10000000;
    localparam longint unsigned RESP_LIMIT_S = 2;
    localparam int unsigned RESP_CYC_DOC = int'(RESP_LIMIT_S * CLK_HZ);
    localparam int unsigned AUTOSAVE_CYC_DEF = 1000;

    // Persistent monitoring state, as kept in non-volatile storage
    typedef struct packed {
        logic smart_en;
        logic autosave_en;
        logic [7:0] as_code;
    } sfch_nv_t;

    localparam sfch_nv_t NV_RST = '{smart_en: 1'b0, autosave_en: 1'b0, as_code: 8'h00};
endpackage : sfch_pkg

//--- rtl/sfch_core.sv
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
// Overview of operation
// - Opcode B0h, Features D9h disables, no data
// - Features D2h controls autosave, no data
// - Features D8h enables monitoring, no data
// - Features D1h reads thresholds by PIO in
// - Cylinders must hold 4Fh/C2h or abort
// - Abort shows ERR, ABRT and drive ready; DRDY here just follows the control register
// - Disable, autosave, thresholds need ready and enabled
// - Disable: BSY, switch off, clear BSY, INTRQ
// - Disabled: no monitoring, saving or feature timers
// - Disabled: abort all but enable, even disable
// - Enabled state kept in persistent storage
// - Count 00h disables autosave, F1h enables
// - Autosave state and code kept persistently
// - Autosave: BSY, apply, clear BSY, INTRQ
// - Autosave unsupported: abort on receipt
// - Autosave never sets BSY; answer within 2s
// - Power and recovery saves still allowed
// - Enable needs ready: BSY, on, clear, INTRQ
// - Repeated enable leaves attribute values alone
// - Thresholds: BSY, fetch, DRQ, INTRQ, 512 bytes
// - Last byte is two's complement checksum
module sfch_core #(
    parameter int unsigned AUTOSAVE_CYC = sfch_pkg::AUTOSAVE_CYC_DEF,
    parameter int unsigned RESP_CYC = sfch_pkg::RESP_CYC_DOC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM register slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Task-file interrupt line
    output logic intrq,
    // Persistent state: loaded after reset, written on change
    input wire sfch_pkg::sfch_nv_t nv_load,
    output sfch_pkg::sfch_nv_t nv_store,
    output logic nv_wr,
    // Threshold store, data answers the address combinationally
    output logic [8:0] thr_addr,
    input wire logic [7:0] thr_data,
    // Attribute saving
    input wire logic power_event,
    output logic autosave_req
);

    // Command sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_EXEC = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_DONE = 5'b01000,
        ST_XFER = 5'b10000
    } sfch_state_t;

    sfch_state_t st_r; // Sequencer state
    logic [7:0] feat_r; // Features
    logic [7:0] sc_r; // Sector count
    logic [7:0] cl_r; // Cylinder low
    logic [7:0] ch_r; // Cylinder high
    logic [7:0] cmd_r; // Latched command code
    logic [1:0] ctrl_r; // Drive ready and autosave support
    logic err_r; // Status error
    logic abrt_r; // Error register abort
    logic drq_r; // Data request
    logic thr_op_r; // Current command is a threshold read
    logic loaded_r; // Persistent state taken in
    sfch_pkg::sfch_nv_t nv_r; // Live monitoring state
    logic [7:0] blk_mem [sfch_pkg::BLK_BYTES]; // Threshold block buffer
    logic [7:0] csum_r; // Running byte sum while fetching
    logic [7:0] rd_ptr_r; // Word pointer for data reads
    logic [31:0] rdata_nxt; // Read mux
    logic [31:0] as_cnt_r; // Autosave period timer
    logic bsy; // Busy status
    logic drdy; // Drive ready status
    logic wtake; // Write completes this edge
    logic rtake; // Read completes this edge
    logic cmd_go; // New command accepted
    logic key_ok; // Cylinder key matches
    logic tf_open; // Task file writable

    // Status terms
    assign bsy = (st_r == ST_EXEC) || (st_r == ST_FETCH);
    assign drdy = ctrl_r[sfch_pkg::CT_DRDY_BIT];
    assign wtake = avs_write && !avs_waitrequest;
    assign rtake = avs_read && !avs_waitrequest;
    assign tf_open = (st_r == ST_IDLE);
    assign cmd_go = wtake && (avs_address == sfch_pkg::OFS_CMD) && tf_open;
    assign key_ok = (cl_r == sfch_pkg::KEY_CYL_LO) && (ch_r == sfch_pkg::KEY_CYL_HI);

    // Bus handshake: one wait cycle, then a single cycle with waitrequest low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            avs_waitrequest <= 1'b1;
        end
        else if (!avs_waitrequest)
        begin
            avs_waitrequest <= 1'b1;
        end
        else if (avs_read || avs_write)
        begin
            avs_waitrequest <= 1'b0;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address)
            sfch_pkg::OFS_FEAT: rdata_nxt[7:0] = feat_r;
            sfch_pkg::OFS_SECCNT: rdata_nxt[7:0] = sc_r;
            sfch_pkg::OFS_CYL_LO: rdata_nxt[7:0] = cl_r;
            sfch_pkg::OFS_CYL_HI: rdata_nxt[7:0] = ch_r;
            sfch_pkg::OFS_STATUS:
            begin
                rdata_nxt[sfch_pkg::ST_BSY_BIT] = bsy;
                rdata_nxt[sfch_pkg::ST_DRDY_BIT] = drdy;
                rdata_nxt[sfch_pkg::ST_DRQ_BIT] = drq_r;
                rdata_nxt[sfch_pkg::ST_ERR_BIT] = err_r;
            end
            sfch_pkg::OFS_ERROR: rdata_nxt[sfch_pkg::ER_ABRT_BIT] = abrt_r;
            sfch_pkg::OFS_DATA:
            begin
                // Low byte first within each 16-bit word
                if (drq_r)
                begin
                    rdata_nxt[7:0] = blk_mem[{rd_ptr_r, 1'b0}];
                    rdata_nxt[15:8] = blk_mem[{rd_ptr_r, 1'b1}];
                end
            end
            sfch_pkg::OFS_CTRL: rdata_nxt[1:0] = ctrl_r;
            sfch_pkg::OFS_STATE: rdata_nxt[9:0] = nv_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is captured while waitrequest is still high
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && avs_waitrequest)
        begin
            avs_readdata <= rdata_nxt;
        end
    end

    // Task-file input registers, writable only in idle; the control register is writable at any time
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            feat_r <= sfch_pkg::TF_RST;
            sc_r <= sfch_pkg::TF_RST;
            cl_r <= sfch_pkg::TF_RST;
            ch_r <= sfch_pkg::TF_RST;
            cmd_r <= sfch_pkg::TF_RST;
            ctrl_r <= sfch_pkg::CTRL_RST;
        end
        else if (wtake)
        begin
            if (tf_open)
            begin
                // Loading while busy is ignored
                unique case (avs_address)
                    sfch_pkg::OFS_FEAT: feat_r <= avs_writedata[7:0];
                    sfch_pkg::OFS_SECCNT: sc_r <= avs_writedata[7:0];
                    sfch_pkg::OFS_CYL_LO: cl_r <= avs_writedata[7:0];
                    sfch_pkg::OFS_CYL_HI: ch_r <= avs_writedata[7:0];
                    sfch_pkg::OFS_CMD: cmd_r <= avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (avs_address == sfch_pkg::OFS_CTRL)
            begin
                ctrl_r <= avs_writedata[1:0];
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= ST_IDLE;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE: if (cmd_go) st_r <= ST_EXEC;
                ST_EXEC:
                begin
                    if (!abrt_nxt() && cmd_r == sfch_pkg::OPC_MONITOR
                        && feat_r == sfch_pkg::SUB_RD_THRESH)
                        st_r <= ST_FETCH;
                    else
                        st_r <= ST_DONE;
                end
                ST_FETCH: if (thr_addr == sfch_pkg::LAST_FETCH) st_r <= ST_DONE;
                ST_DONE: st_r <= thr_op_r ? ST_XFER : ST_IDLE;
                ST_XFER:
                begin
                    if (rtake && avs_address == sfch_pkg::OFS_DATA && rd_ptr_r == sfch_pkg::LAST_WORD)
                        st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Decide whether the latched command must be aborted
    function automatic logic abrt_nxt();
        logic bad;
        bad = 1'b1;
        if (cmd_r == sfch_pkg::OPC_MONITOR && drdy && key_ok)
        begin
            unique case (feat_r)
                sfch_pkg::SUB_ENABLE: bad = 1'b0;
                sfch_pkg::SUB_DISABLE: bad = !nv_r.smart_en;
                sfch_pkg::SUB_AUTOSAVE:
                    bad = !nv_r.smart_en || !ctrl_r[sfch_pkg::CT_ASSUP_BIT];
                sfch_pkg::SUB_RD_THRESH: bad = !nv_r.smart_en;
                default: bad = 1'b1;
            endcase
        end
        return bad;
    endfunction : abrt_nxt

    // Error reporting: cleared on a new command, set when the command is refused
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_r <= 1'b0;
            abrt_r <= 1'b0;
            thr_op_r <= 1'b0;
        end
        else if (cmd_go)
        begin
            err_r <= 1'b0;
            abrt_r <= 1'b0;
            thr_op_r <= 1'b0;
        end
        else if (st_r == ST_EXEC)
        begin
            err_r <= abrt_nxt();
            abrt_r <= abrt_nxt();
            thr_op_r <= !abrt_nxt() && feat_r == sfch_pkg::SUB_RD_THRESH;
        end
    end

    // Monitoring state: taken from storage after reset, then changed by commands
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nv_r <= sfch_pkg::NV_RST;
            loaded_r <= 1'b0;
            nv_wr <= 1'b0;
        end
        else if (!loaded_r)
        begin
            nv_r <= nv_load;
            loaded_r <= 1'b1;
            nv_wr <= 1'b0;
        end
        else if (st_r == ST_EXEC && !abrt_nxt())
        begin
            nv_wr <= 1'b0;
            if (feat_r == sfch_pkg::SUB_ENABLE)
            begin
                // Attribute values are untouched by a repeated enable
                nv_r.smart_en <= 1'b1;
                nv_wr <= 1'b1;
            end
            else if (feat_r == sfch_pkg::SUB_DISABLE)
            begin
                nv_r.smart_en <= 1'b0;
                nv_wr <= 1'b1;
            end
            else if (feat_r == sfch_pkg::SUB_AUTOSAVE)
            begin
                // Other nonzero codes enable and are kept as given
                nv_r.autosave_en <= (sc_r != sfch_pkg::AS_OFF);
                nv_r.as_code <= sc_r;
                nv_wr <= 1'b1;
            end
        end
        else
        begin
            nv_wr <= 1'b0;
        end
    end

    // Persistent copy follows the live state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nv_store <= sfch_pkg::NV_RST;
        end
        else
        begin
            nv_store <= nv_r;
        end
    end

    // Threshold fetch into the block buffer with running checksum
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            thr_addr <= 9'h000;
            csum_r <= 8'h00;
        end
        else if (st_r == ST_EXEC)
        begin
            thr_addr <= 9'h000;
            csum_r <= 8'h00;
        end
        else if (st_r == ST_FETCH)
        begin
            csum_r <= csum_r + thr_data;
            if (thr_addr != sfch_pkg::LAST_FETCH)
                thr_addr <= thr_addr + 9'h001;
        end
    end

    // Buffer writes; the final byte is the two's complement of the sum
    always_ff @(posedge clk)
    begin
        if (st_r == ST_FETCH)
        begin
            blk_mem[thr_addr] <= thr_data;
            if (thr_addr == sfch_pkg::LAST_FETCH)
                blk_mem[sfch_pkg::BLK_BYTES - 1] <= 8'h00 - (csum_r + thr_data);
        end
    end

    // Data request and read pointer for the 256-word transfer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            drq_r <= 1'b0;
            rd_ptr_r <= 8'h00;
        end
        else if (st_r == ST_FETCH && thr_addr == sfch_pkg::LAST_FETCH)
        begin
            drq_r <= 1'b1;
            rd_ptr_r <= 8'h00;
        end
        else if (drq_r && rtake && avs_address == sfch_pkg::OFS_DATA)
        begin
            rd_ptr_r <= rd_ptr_r + 8'h01;
            if (rd_ptr_r == sfch_pkg::LAST_WORD)
                drq_r <= 1'b0;
        end
    end

    // Interrupt: raised one cycle after BSY drops, cleared by status read or new command
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            intrq <= 1'b0;
        end
        else if (st_r == ST_DONE)
        begin
            intrq <= 1'b1;
        end
        else if (cmd_go || (rtake && avs_address == sfch_pkg::OFS_STATUS))
        begin
            intrq <= 1'b0;
        end
    end

    // Autosave timer runs only while monitoring and autosave are both on;
    // it never touches BSY or ready, so commands are served unhindered
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            as_cnt_r <= 32'h0000_0000;
            autosave_req <= 1'b0;
        end
        else if (!nv_r.smart_en)
        begin
            as_cnt_r <= 32'h0000_0000;
            autosave_req <= 1'b0;
        end
        else
        begin
            // Power and recovery events save even with autosave off
            autosave_req <= power_event;
            if (!nv_r.autosave_en)
                as_cnt_r <= 32'h0000_0000;
            else if (as_cnt_r >= AUTOSAVE_CYC - 1)
            begin
                as_cnt_r <= 32'h0000_0000;
                autosave_req <= 1'b1;
            end
            else
                as_cnt_r <= as_cnt_r + 32'h0000_0001;
        end
    end

    // Cycles since a command was accepted, for the response bound
    logic [31:0] resp_cnt_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            resp_cnt_r <= 32'h0000_0000;
        else if (cmd_go)
            resp_cnt_r <= 32'h0000_0001;
        else if (resp_cnt_r != 32'h0000_0000 && st_r != ST_DONE)
            resp_cnt_r <= resp_cnt_r + 32'h0000_0001;
        else
            resp_cnt_r <= 32'h0000_0000;
    end

    chk_cmd_bsy: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go |=> bsy) else $error("busy not raised on command");
    chk_bad_key: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && !(avs_writedata[7:0] == sfch_pkg::OPC_MONITOR && key_ok)
        |-> ##2 (err_r && abrt_r && !bsy)) else $error("bad key not aborted");
    chk_disable_off: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && avs_writedata[7:0] == sfch_pkg::OPC_MONITOR && key_ok && drdy
        && feat_r == sfch_pkg::SUB_DISABLE && nv_r.smart_en
        |-> ##2 (!nv_r.smart_en && !err_r) ##1 intrq) else $error("disable failed");
    chk_enable_on: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && avs_writedata[7:0] == sfch_pkg::OPC_MONITOR && key_ok && drdy
        && feat_r == sfch_pkg::SUB_ENABLE
        |-> ##2 (nv_r.smart_en && !err_r)) else $error("enable failed");
    chk_off_abort: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && !nv_r.smart_en && feat_r != sfch_pkg::SUB_ENABLE
        |-> ##2 (err_r && abrt_r)) else $error("disabled command not aborted");
    chk_intrq_order: assert property (@(posedge clk) disable iff (!resetn)
        $rose(intrq) |-> !bsy && !$past(bsy)) else $error("interrupt before busy clear");
    chk_no_save_off: assert property (@(posedge clk) disable iff (!resetn)
        loaded_r && !nv_r.smart_en |=> !autosave_req) else $error("save while disabled");
    chk_as_clear: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && avs_writedata[7:0] == sfch_pkg::OPC_MONITOR && key_ok && drdy
        && feat_r == sfch_pkg::SUB_AUTOSAVE && sc_r == sfch_pkg::AS_OFF && nv_r.smart_en
        && ctrl_r[sfch_pkg::CT_ASSUP_BIT] |-> ##2 !nv_r.autosave_en)
        else $error("autosave not cleared");
    chk_as_unsup: assert property (@(posedge clk) disable iff (!resetn)
        cmd_go && feat_r == sfch_pkg::SUB_AUTOSAVE && !ctrl_r[sfch_pkg::CT_ASSUP_BIT]
        |-> ##2 abrt_r) else $error("unsupported autosave not aborted");
    chk_drq_rise: assert property (@(posedge clk) disable iff (!resetn)
        $rose(drq_r) |-> !bsy ##1 intrq) else $error("data phase order wrong");
    chk_checksum: assert property (@(posedge clk) disable iff (!resetn)
        st_r == ST_DONE && thr_op_r
        |-> (8'(csum_r + blk_mem[sfch_pkg::BLK_BYTES - 1]) == 8'h00))
        else $error("checksum byte wrong");
    chk_resp_bound: assert property (@(posedge clk) disable iff (!resetn)
        resp_cnt_r < RESP_CYC) else $error("command response too slow");

endmodule : sfch_core

//--- tb/sfch_nv_model.sv
`timescale 1ns/10ps
// Far side storage: persistent state and factory threshold bytes
module sfch_nv_model (
    // Clock
    input wire logic clk,
    // Persistent state
    output sfch_pkg::sfch_nv_t nv_load,
    input wire sfch_pkg::sfch_nv_t nv_store,
    input wire logic nv_wr,
    // Threshold store
    input wire logic [8:0] thr_addr,
    output logic [7:0] thr_data
);
    logic wr_d_r; // The stored copy is valid the cycle after the pulse
    initial nv_load = sfch_pkg::NV_RST;
    // Not cleared by reset, as real storage outlives power cycles
    always @(posedge clk)
    begin
        wr_d_r <= nv_wr;
        if (wr_d_r === 1'b1)
            nv_load <= nv_store;
    end
    // Fixed factory pattern, answered in the same cycle
    assign thr_data = thr_addr[7:0] ^ {thr_addr[8], 7'h35};
endmodule : sfch_nv_model

//--- tb/smart_feature_command_handler_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the monitoring command handler
module smart_feature_command_handler_tb_top;
    // Bus, interrupt, storage and save signals
    logic clk, resetn, avs_read, avs_write, avs_waitrequest, intrq, nv_wr;
    logic power_event, autosave_req;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    sfch_pkg::sfch_nv_t nv_load, nv_store;
    logic [8:0] thr_addr;
    logic [7:0] thr_data;
    int fails = 0, checked = 0, saves = 0;
    logic drdy = 1'b1; // Expected drive ready level

    sfch_core #(.AUTOSAVE_CYC(10), .RESP_CYC(1000)) dut (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .intrq(intrq), .nv_load(nv_load),
        .nv_store(nv_store), .nv_wr(nv_wr), .thr_addr(thr_addr), .thr_data(thr_data),
        .power_event(power_event), .autosave_req(autosave_req));
    sfch_nv_model nvm (.clk(clk), .nv_load(nv_load), .nv_store(nv_store), .nv_wr(nv_wr),
        .thr_addr(thr_addr), .thr_data(thr_data));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count save requests
    always @(posedge clk)
        if (autosave_req === 1'b1)
            saves++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check

    // One bus access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        // No own limit: only the watchdog ends a wait for the slave
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Read the state word and compare it
    task automatic st(input logic [31:0] e);
        bus(1'b0, sfch_pkg::OFS_STATE, 8'h00);
        check(q & 32'h3FF, e, "state");
    endtask : st

    // Full command with completion and error checks
    task automatic cmd(input logic [7:0] op, f, sc, lo, hi, input logic err);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, sfch_pkg::OFS_STATUS, 8'h00);
        end
        while ((q[7] | q[3]) !== 1'b0);
        bus(1'b1, sfch_pkg::OFS_FEAT, f);
        bus(1'b1, sfch_pkg::OFS_SECCNT, sc);
        bus(1'b1, sfch_pkg::OFS_CYL_LO, lo);
        bus(1'b1, sfch_pkg::OFS_CYL_HI, hi);
        bus(1'b1, sfch_pkg::OFS_CMD, op);
        n = 0;
        while (intrq !== 1'b1 && n < 700)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, intrq}, 32'h1, "completion interrupt");
        bus(1'b0, sfch_pkg::OFS_STATUS, 8'h00);
        check(q & 32'hC9, {24'h0, 1'b0, drdy, 2'b0, f == 8'hD1 && !err, 2'b0, err}, "status");
        repeat (2) @(negedge clk);
        check({31'h0, intrq}, 32'h0, "interrupt cleared by status read");
        bus(1'b0, sfch_pkg::OFS_ERROR, 8'h00);
        check({31'h0, q[2]}, {31'h0, err}, "abort bit");
    endtask : cmd

    // Subcommand with the correct opcode and key
    task automatic sub(input logic [7:0] f, sc, input logic err);
        cmd(sfch_pkg::OPC_MONITOR, f, sc, sfch_pkg::KEY_CYL_LO, sfch_pkg::KEY_CYL_HI, err);
    endtask : sub

    task automatic t_off;
        st(32'h000);
        bus(1'b0, 6'h3C, 8'h00);
        check(q, 32'h0, "unmapped read");
        sub(sfch_pkg::SUB_DISABLE, 8'h00, 1'b1);
        sub(sfch_pkg::SUB_AUTOSAVE, 8'hF1, 1'b1);
        sub(sfch_pkg::SUB_RD_THRESH, 8'h00, 1'b1);
        st(32'h000);
        $display("TEST done: refused while off");
    endtask : t_off

    task automatic t_enable;
        sub(sfch_pkg::SUB_ENABLE, 8'h00, 1'b0);
        st(32'h200);
        sub(sfch_pkg::SUB_ENABLE, 8'h00, 1'b0);
        st(32'h200);
        cmd(8'hB0, 8'hD8, 8'h00, 8'h4E, 8'hC2, 1'b1);
        cmd(8'hB0, 8'hD2, 8'hF1, 8'h4F, 8'hC3, 1'b1);
        cmd(8'hB0, 8'hD0, 8'h00, 8'h4F, 8'hC2, 1'b1);
        cmd(8'hB1, 8'hD2, 8'hF1, 8'h4F, 8'hC2, 1'b1);
        st(32'h200);
        $display("TEST done: enable and bad inputs");
    endtask : t_enable

    task automatic t_autosave;
        sub(sfch_pkg::SUB_AUTOSAVE, 8'hF1, 1'b0);
        st(32'h3F1);
        saves = 0;
        repeat (60) @(posedge clk);
        check({31'h0, saves > 0}, 32'h1, "periodic saves");
        bus(1'b0, sfch_pkg::OFS_STATUS, 8'h00);
        check(q & 32'hC0, 32'h40, "ready, not busy while saving");
        sub(sfch_pkg::SUB_AUTOSAVE, 8'h00, 1'b0);
        st(32'h200);
        saves = 0;
        repeat (60) @(posedge clk);
        check(saves, 0, "no periodic saves when off");
        power_event <= 1'b1;
        @(posedge clk);
        power_event <= 1'b0;
        repeat (5) @(posedge clk);
        check(saves, 1, "save at power event");
        sub(sfch_pkg::SUB_AUTOSAVE, 8'h7A, 1'b0);
        st(32'h37A);
        sub(sfch_pkg::SUB_AUTOSAVE, 8'hF1, 1'b0);
        $display("TEST done: autosave");
    endtask : t_autosave

    task automatic t_thresh;
        logic [7:0] lo, hi, sum;
        sum = 8'h00;
        sub(sfch_pkg::SUB_RD_THRESH, 8'h00, 1'b0);
        for (int i = 0; i < 256; i++)
        begin
            lo = 8'(2 * i) ^ {i[7], 7'h35};
            hi = 8'(2 * i + 1) ^ {i[7], 7'h35};
            if (i == 255)
                hi = 8'h00 - (sum + lo);
            sum = sum + lo + hi;
            bus(1'b0, sfch_pkg::OFS_DATA, 8'h00);
            check(q & 32'hFFFF, {16'h0, hi, lo}, "threshold word");
        end
        bus(1'b0, sfch_pkg::OFS_STATUS, 8'h00);
        check(q & 32'h88, 32'h0, "transfer done");
        $display("TEST done: thresholds");
    endtask : t_thresh

    task automatic t_power;
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        st(32'h3F1);
        $display("TEST done: power cycle");
    endtask : t_power

    task automatic t_disable;
        sub(sfch_pkg::SUB_DISABLE, 8'h00, 1'b0);
        // Monitoring off; autosave setting and code are kept as stored
        st(32'h1F1);
        saves = 0;
        repeat (60) @(posedge clk);
        check(saves, 0, "no saves while off");
        sub(sfch_pkg::SUB_DISABLE, 8'h00, 1'b1);
        $display("TEST done: disable");
    endtask : t_disable

    task automatic t_ctrl;
        bus(1'b1, sfch_pkg::OFS_CTRL, 8'h02);
        drdy = 1'b0;
        sub(sfch_pkg::SUB_ENABLE, 8'h00, 1'b1);
        bus(1'b1, sfch_pkg::OFS_CTRL, 8'h01);
        drdy = 1'b1;
        sub(sfch_pkg::SUB_ENABLE, 8'h00, 1'b0);
        sub(sfch_pkg::SUB_AUTOSAVE, 8'hF1, 1'b1);
        bus(1'b0, sfch_pkg::OFS_CTRL, 8'h00);
        check(q & 32'h3, 32'h1, "control readback");
        $display("TEST done: drive ready and support");
    endtask : t_ctrl

    // Verdict and end of run
    task automatic complete_run;
        $display("Counts: checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial
    begin
        {avs_read, avs_write, power_event, resetn} = 4'h0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_off();
        t_enable();
        t_autosave();
        t_thresh();
        t_power();
        t_disable();
        t_ctrl();
        complete_run();
    end
    // Watchdog against a hang
    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        complete_run();
    end
endmodule : smart_feature_command_handler_tb_top
